// ### inc/dcdc_pkg.sv
// package for the dual converter data control block
package dcdc_pkg;
  localparam int          DCDC_ADDR_W        = 8;
  localparam int          DCDC_DATA_W        = 8;
  localparam int          DCDC_CODE_W        = 12;
  localparam logic [7:0]  DCDC_CH0_LOW_ADDR  = 8'hf9;
  localparam logic [7:0]  DCDC_CH0_HIGH_ADDR = 8'hfa;
  localparam logic [7:0]  DCDC_CH1_LOW_ADDR  = 8'hfb;
  localparam logic [7:0]  DCDC_CH1_HIGH_ADDR = 8'hfc;
  localparam logic [7:0]  DCDC_CTRL_ADDR     = 8'hfd;
  localparam logic [7:0]  DCDC_DATA_RESET    = 8'h00;
  localparam logic [7:0]  DCDC_CTRL_RESET    = 8'h04;
  localparam int          DCDC_BIT_MODE8     = 7;
  localparam int          DCDC_BIT_RANGE1    = 6;
  localparam int          DCDC_BIT_RANGE0    = 5;
  localparam int          DCDC_BIT_CLEAR1    = 4;
  localparam int          DCDC_BIT_CLEAR0    = 3;
  localparam int          DCDC_BIT_SYNC      = 2;
  localparam int          DCDC_BIT_POWER1    = 1;
  localparam int          DCDC_BIT_POWER0    = 0;
  localparam logic [11:0] DCDC_CODE_ZERO     = 12'h000;

  // what one converter core receives
  typedef struct packed {
    logic [11:0] code;
    logic        range_supply;
    logic        power_on;
  } dcdc_chan_s;
endpackage : dcdc_pkg

// ### rtl/dcdc_channel.sv
// one converter channel: code assembly, update latch and clear
`timescale 1ns/1ps
`default_nettype none
module dcdc_channel
  import dcdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  data_low,
  input  wire logic [7:0]  data_high,
  input  wire logic        mode8,
  input  wire logic        range_supply,
  input  wire logic        output_clear_n,
  input  wire logic        power_on,
  input  wire logic        load,
  output dcdc_pkg::dcdc_chan_s chan
);
  import dcdc_pkg::*;

  logic [11:0] held_code;
  logic [11:0] next_code;

  // 8-bit mode takes the low byte only; the high byte is dropped
  assign next_code = mode8 ? {4'h0, data_low} : {data_high[3:0], data_low};

  always_ff @(posedge clk)
  begin
    if (!nrst)
      held_code <= DCDC_CODE_ZERO;
    else if (load)
      held_code <= next_code;
  end

  // clear forces zero without losing the held code; one driver for the whole struct
  assign chan = '{code:         output_clear_n ? held_code : DCDC_CODE_ZERO,
                  range_supply: range_supply,
                  power_on:     power_on};
endmodule : dcdc_channel
`default_nettype wire

// ### rtl/dcdc_top.sv
// register file and update control for the two converter channels
`timescale 1ns/1ps
`default_nettype none
module dcdc_top
  import dcdc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [7:0]            sfr_addr,
  input  wire logic [7:0]            sfr_wdata,
  input  wire logic                  sfr_wr,
  input  wire logic                  sfr_rd,
  output logic      [7:0]            sfr_rdata,
  output logic                       sfr_sel,
  output dcdc_pkg::dcdc_chan_s       ch0,
  output dcdc_pkg::dcdc_chan_s       ch1
);
  import dcdc_pkg::*;

  // the register map holds exactly two channels
  localparam int CHANNELS = 2;

  // software-visible registers
  logic [7:0] ch0_data_low;
  logic [7:0] ch0_data_high;
  logic [7:0] ch1_data_low;
  logic [7:0] ch1_data_high;
  logic [7:0] converter_control;

  // address decode
  wire hit_ch0_low  = sfr_addr == DCDC_CH0_LOW_ADDR;
  wire hit_ch0_high = sfr_addr == DCDC_CH0_HIGH_ADDR;
  wire hit_ch1_low  = sfr_addr == DCDC_CH1_LOW_ADDR;
  wire hit_ch1_high = sfr_addr == DCDC_CH1_HIGH_ADDR;
  wire hit_ctrl     = sfr_addr == DCDC_CTRL_ADDR;

  // write strobes, one per register
  wire wr_ch0_low   = sfr_wr && hit_ch0_low;
  wire wr_ch0_high  = sfr_wr && hit_ch0_high;
  wire wr_ch1_low   = sfr_wr && hit_ch1_low;
  wire wr_ch1_high  = sfr_wr && hit_ch1_high;
  wire wr_ctrl      = sfr_wr && hit_ctrl;

  // control fields
  wire mode8              = converter_control[DCDC_BIT_MODE8];
  wire ch1_range_select   = converter_control[DCDC_BIT_RANGE1];
  wire ch0_range_select   = converter_control[DCDC_BIT_RANGE0];
  wire ch1_output_clear_n = converter_control[DCDC_BIT_CLEAR1];
  wire ch0_output_clear_n = converter_control[DCDC_BIT_CLEAR0];
  wire sync_now           = converter_control[DCDC_BIT_SYNC];
  wire ch1_power_on       = converter_control[DCDC_BIT_POWER1];
  wire ch0_power_on       = converter_control[DCDC_BIT_POWER0];

  // only a 0->1 step of the sync bit fires; rewriting it high reloads nothing
  wire sync_rise = wr_ctrl && !sync_now && sfr_wdata[DCDC_BIT_SYNC];

  // next register values: hold unless addressed by a write
  wire [7:0] next_ch0_data_low      = wr_ch0_low  ? sfr_wdata : ch0_data_low;
  wire [7:0] next_ch0_data_high     = wr_ch0_high ? sfr_wdata : ch0_data_high;
  wire [7:0] next_ch1_data_low      = wr_ch1_low  ? sfr_wdata : ch1_data_low;
  wire [7:0] next_ch1_data_high     = wr_ch1_high ? sfr_wdata : ch1_data_high;
  wire [7:0] next_converter_control = wr_ctrl     ? sfr_wdata : converter_control;

  // per-channel views so the channel logic is one loop
  wire [CHANNELS-1:0][7:0] low_byte  = {ch1_data_low, ch0_data_low};
  wire [CHANNELS-1:0][7:0] high_byte = {ch1_data_high, ch0_data_high};
  wire [CHANNELS-1:0]      low_write = {wr_ch1_low, wr_ch0_low};
  wire [CHANNELS-1:0]      range_sel = {ch1_range_select, ch0_range_select};
  wire [CHANNELS-1:0]      clear_n   = {ch1_output_clear_n, ch0_output_clear_n};
  wire [CHANNELS-1:0]      power_on  = {ch1_power_on, ch0_power_on};
  wire [CHANNELS-1:0]      next_load;
  logic [CHANNELS-1:0]     load_q;
  wire dcdc_chan_s [CHANNELS-1:0] chan_out;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      ch0_data_low <= DCDC_DATA_RESET;
    else
      ch0_data_low <= next_ch0_data_low;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      ch0_data_high <= DCDC_DATA_RESET;
    else
      ch0_data_high <= next_ch0_data_high;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      ch1_data_low <= DCDC_DATA_RESET;
    else
      ch1_data_low <= next_ch1_data_low;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      ch1_data_high <= DCDC_DATA_RESET;
    else
      ch1_data_high <= next_ch1_data_high;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      converter_control <= DCDC_CTRL_RESET;
    else
      converter_control <= next_converter_control;
  end

  // the byte lands at the write edge, so the load pulse trails it by one edge
  always_ff @(posedge clk)
  begin
    if (!nrst)
      load_q <= '0;
    else
      load_q <= next_load;
  end

  // full byte reads back; the converter alone drops unused bits
  wire [7:0] next_rdata = hit_ch0_low  ? ch0_data_low  :
                          hit_ch0_high ? ch0_data_high :
                          hit_ch1_low  ? ch1_data_low  :
                          hit_ch1_high ? ch1_data_high :
                          hit_ctrl     ? converter_control : 8'h00;
  assign sfr_sel = hit_ch0_low || hit_ch0_high || hit_ch1_low || hit_ch1_high || hit_ctrl;

  // registered read data stands until the next read strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= next_rdata;
  end

  for (genvar g = 0; g < CHANNELS; g++)
  begin : g_chan
    wire [7:0] channel_data_low  = low_byte[g];
    wire [7:0] channel_data_high = high_byte[g];

    // immediate mode follows the low byte; a sync rise loads both at once
    assign next_load[g] = (low_write[g] && sync_now) || sync_rise;

    dcdc_channel u_chan (
      .clk            (clk),
      .nrst           (nrst),
      .data_low       (channel_data_low),
      .data_high      (channel_data_high),
      .mode8          (mode8),
      .range_supply   (range_sel[g]),
      .output_clear_n (clear_n[g]),
      .power_on       (power_on[g]),
      .load           (load_q[g]),
      .chan           (chan_out[g])
    );
  end

  assign ch0 = chan_out[0];
  assign ch1 = chan_out[1];
endmodule : dcdc_top
`default_nettype wire

// ### verif/dcdc_top_asserts.sv
// port-level assertions for the converter data control block
`timescale 1ns/1ps
`default_nettype none
module dcdc_top_asserts
  import dcdc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic [7:0]           sfr_addr,
  input wire logic [7:0]           sfr_wdata,
  input wire logic                 sfr_wr,
  input wire logic                 sfr_rd,
  input wire logic [7:0]           sfr_rdata,
  input wire logic                 sfr_sel,
  input wire dcdc_pkg::dcdc_chan_s ch0,
  input wire dcdc_pkg::dcdc_chan_s ch1
);
  import dcdc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire wctl = sfr_wr && sfr_addr == DCDC_CTRL_ADDR;
  sequence s_arm; wctl && !sfr_wdata[2]; endsequence
  sequence s_fire; wctl && sfr_wdata[2] && sfr_wdata[7] && sfr_wdata[3]; endsequence
  property p_sel; sfr_sel == (sfr_addr inside {[8'hf9:8'hfd]}); endproperty
  property p_rst; disable iff (1'b0) !nrst |=> sfr_rdata == 8'h00 && ch0 == '0 && ch1 == '0; endproperty
  property p_pwr; wctl |=> {ch1.power_on, ch0.power_on} == $past(sfr_wdata[1:0]); endproperty
  property p_rng; wctl |=> {ch1.range_supply, ch0.range_supply} == $past(sfr_wdata[6:5]); endproperty
  property p_ch0_output_clear_n; wctl && !sfr_wdata[3] |=> ch0.code == DCDC_CODE_ZERO; endproperty
  property p_ch1_output_clear_n; wctl && !sfr_wdata[4] |=> ch1.code == DCDC_CODE_ZERO; endproperty
  property p_unmap; sfr_rd && !sfr_sel |=> sfr_rdata == 8'h00; endproperty
  property p_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
  property p_mode8; s_arm ##[1:4] s_fire |=> ##1 ch0.code[11:8] == 4'h0; endproperty
  a_sel: assert property (p_sel) else $error("decode wrong");
  a_rst: assert property (p_rst) else $error("reset value wrong");
  a_pwr: assert property (p_pwr) else $error("power wrong");
  a_rng: assert property (p_rng) else $error("range wrong");
  a_ch0_output_clear_n: assert property (p_ch0_output_clear_n) else $error("ch0 not cleared");
  a_ch1_output_clear_n: assert property (p_ch1_output_clear_n) else $error("ch1 not cleared");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_mode8: assert property (p_mode8) else $error("8-bit code wide");
endmodule : dcdc_top_asserts
bind dcdc_top dcdc_top_asserts dcdc_top_asserts_i (
  .clk       (clk),
  .nrst      (nrst),
  .sfr_addr  (sfr_addr),
  .sfr_wdata (sfr_wdata),
  .sfr_wr    (sfr_wr),
  .sfr_rd    (sfr_rd),
  .sfr_rdata (sfr_rdata),
  .sfr_sel   (sfr_sel),
  .ch0       (ch0),
  .ch1       (ch1)
);
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the converter data control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcdc_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] a = 8'h00;
  logic [7:0] d = 8'h00;
  logic [7:0] rdata;
  logic       sel;
  dcdc_chan_s c0;
  dcdc_chan_s c1;
  int         mismatches = 0;
  int         checked = 0;
  dcdc_top dcdc_top_i (.clk(clk), .nrst(nrst), .sfr_addr(a), .sfr_wdata(d), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_rdata(rdata), .sfr_sel(sel), .ch0(c0), .ch1(c1));
  initial forever #2.5 clk = ~clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wrt(input logic [7:0] ad, input logic [7:0] dd);
    @(posedge clk);
    a <= ad;
    d <= dd;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  task rdc(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(32'(rdata), 32'(e));
    chk(32'(sel), 32'(ad inside {[DCDC_CH0_LOW_ADDR:DCDC_CTRL_ADDR]}));
  endtask : rdc
  // code lands one edge after the write edge
  task settle;
    @(posedge clk);
    @(negedge clk);
  endtask : settle
  task summarize;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    for (int i = 0; i < 4; i++)
      rdc(8'hf9 + 8'(i), 8'h00);
    rdc(8'hfd, 8'h04);
    rdc(8'hf8, 8'h00);
    chk(32'(c0), 32'h0);
    wrt(8'hfd, 8'h7f);
    settle();
    chk(32'({c1.range_supply, c0.range_supply, c1.power_on, c0.power_on}), 32'hf);
    wrt(8'hfa, 8'hf5);
    wrt(8'hf9, 8'h34);
    settle();
    chk(32'(c0.code), 32'h534);
    rdc(8'hfa, 8'hf5);
    wrt(8'hfd, 8'h7b);
    wrt(8'hfc, 8'h01);
    wrt(8'hfb, 8'h9a);
    settle();
    chk(32'(c1.code), 32'h0);
    wrt(8'hfd, 8'h7f);
    settle();
    chk(32'({c1.code, c0.code}), 32'h19a534);
    wrt(8'hfb, 8'h55);
    settle();
    chk(32'({c1.code, c0.code}), 32'h155534);
    wrt(8'hfd, 8'hfb);
    wrt(8'hfd, 8'hff);
    settle();
    chk(32'({c1.code, c0.code}), 32'h055034);
    // distinct bits per channel catch a swapped field
    wrt(8'hfd, 8'hd5);
    settle();
    chk(32'({c1, c0}), 32'h558001);
    wrt(8'hfd, 8'h84);
    settle();
    chk(32'({c1, c0}), 32'h0);
    // second reset in mid-run must restore power-on values
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(8'hfb, 8'h00);
    rdc(8'hfd, 8'h04);
    chk(32'({c1, c0}), 32'h0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
